// [design/twe_pkg.sv]
// Shared constants and types for the two-wire EEPROM write slave
package twe_pkg;
  localparam int            ADDR_W         = 7;
  localparam int            MEM_DEPTH      = 128;
  localparam int            PAGE_BYTES     = 4;
  localparam int            BIT_LAST       = 7;
  localparam int            BIT_ACK        = 8;
  localparam logic [7:0]    MEM_RESET_VAL  = 8'hff;
  localparam logic [2:0]    SYNC_RESET_VAL = 3'h7;
  localparam int            CLK_PERIOD_NS  = 10;
  localparam int            PROG_TIME_MS   = 10;
  localparam int            PROG_CYCLES    = (PROG_TIME_MS * 1000000) / CLK_PERIOD_NS;

  typedef enum logic [4:0] {
    TWE_IDLE  = 5'b00001,
    TWE_ADDR  = 5'b00010,
    TWE_WDATA = 5'b00100,
    TWE_WAIT  = 5'b01000,
    TWE_PROG  = 5'b10000
  } twe_state_t;

  typedef struct packed {
    logic sda_o;
    logic sda_oe;
  } twe_pin_t;

  typedef struct packed {
    logic [7:0] data;
    logic       valid;
  } twe_latch_t;
endpackage

// [design/twe_slave.sv]
// Two-wire EEPROM slave: address byte, byte and page write, program cycle
// What this block does
// - After START one byte is shifted MSB first: seven address bits, direction.
// - Eighth bit is direction: one means read, zero means write.
// - Accepted address byte is acknowledged by pulling data low in ninth clock.
// - After a write address acknowledge, the block waits for a data byte.
// - Write-protect high from START to address end blocks writes and data acks.
// - Byte write: one data byte, acknowledged, then master sends STOP.
// - Page write takes one to four bytes sharing the row address bits.
// - Each data byte of a page write is acknowledged on its own.
// - Only the two low address bits increment, wrapping within the row.
// - STOP after a write launches the self-timed program cycle.
// - During the program cycle the bus clock, data and write-protect inputs are ignored.
// - Program cycle finishes within ten milliseconds.
// - Data line is released for the whole program cycle.
// - START is data falling with clock high; STOP is data rising with clock high.
// - Data is sampled on the first eight rising clock edges of each byte.
// - Address bytes go unacknowledged while busy, acknowledged once finished.
// - Write-protect samplers reset low, so protection is off after reset.
`timescale 1ns/1ns
module twe_slave #(
  parameter int PROG_CYCLES = twe_pkg::PROG_CYCLES
) (
  input  wire logic              clock,
  input  wire logic              reset_n,
  input  wire logic              scl_i,
  input  wire logic              sda_i,
  input  wire logic              write_protect_input,
  output twe_pkg::twe_pin_t      sda_pin,
  output logic                   prog_busy,
  output logic [7:0]             rd_data,
  input  wire logic [6:0]        rd_addr
);
  // Three-stage samplers; a level counts once stages two and three agree
  logic [2:0] scl_s_r, sda_s_r, wp_s_r;
  logic [2:0] scl_s_nxt, sda_s_nxt, wp_s_nxt;
  logic       scl_q_r, sda_q_r, wp_q_r;
  logic       scl_q_nxt, sda_q_nxt, wp_q_nxt;
  // Filtered levels with one cycle of history for edge finding
  logic       scl_d_r, sda_d_r;

  // A single disagreeing sample is a glitch and leaves the level alone
  function automatic logic filt_level(input logic [2:0] stages, input logic level);
    return (stages[1] == stages[2]) ? stages[2] : level;
  endfunction

  always_comb begin
    scl_s_nxt = {scl_s_r[1:0], scl_i};
    sda_s_nxt = {sda_s_r[1:0], sda_i};
    wp_s_nxt  = {wp_s_r[1:0], write_protect_input};
    scl_q_nxt = filt_level(scl_s_r, scl_q_r);
    sda_q_nxt = filt_level(sda_s_r, sda_q_r);
    wp_q_nxt  = filt_level(wp_s_r, wp_q_r);
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      scl_s_r <= twe_pkg::SYNC_RESET_VAL;
      sda_s_r <= twe_pkg::SYNC_RESET_VAL;
      wp_s_r  <= 3'h0;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      wp_q_r  <= 1'b0;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_s_r <= scl_s_nxt;
      sda_s_r <= sda_s_nxt;
      wp_s_r  <= wp_s_nxt;
      scl_q_r <= scl_q_nxt;
      sda_q_r <= sda_q_nxt;
      wp_q_r  <= wp_q_nxt;
      scl_d_r <= scl_q_r;
      sda_d_r <= sda_q_r;
    end
  end

  logic scl_rise, scl_fall, start_ev, stop_ev;
  assign scl_rise = scl_q_r & ~scl_d_r;
  assign scl_fall = ~scl_q_r & scl_d_r;
  // Both edges need the clock steady high over the data change
  assign start_ev = scl_q_r & scl_d_r & sda_d_r & ~sda_q_r;
  assign stop_ev  = scl_q_r & scl_d_r & ~sda_d_r & sda_q_r;

  twe_pkg::twe_state_t state_r, state_nxt;
  logic [3:0]  bit_r, bit_nxt;
  logic [7:0]  shift_r, shift_nxt;
  logic [6:0]  addr_r, addr_nxt;
  logic        wp_seen_r, wp_seen_nxt;
  logic        ack_r, ack_nxt;
  logic        wr_any_r, wr_any_nxt;
  logic [31:0] prog_cnt_r, prog_cnt_nxt;
  twe_pkg::twe_latch_t [twe_pkg::PAGE_BYTES-1:0] page_r, page_nxt;
  logic [7:0]  mem_r [twe_pkg::MEM_DEPTH];

  always_comb begin
    state_nxt      = state_r;
    bit_nxt        = bit_r;
    shift_nxt      = shift_r;
    addr_nxt       = addr_r;
    wp_seen_nxt    = wp_seen_r;
    ack_nxt        = ack_r;
    wr_any_nxt     = wr_any_r;
    prog_cnt_nxt   = prog_cnt_r;
    page_nxt       = page_r;
    unique case (state_r)
      twe_pkg::TWE_PROG: begin
        // Bus is ignored entirely here
        // Program time is fixed at the maximum count; no early finish
        ack_nxt = 1'b0;
        if (prog_cnt_r + 32'h1 >= 32'(PROG_CYCLES)) begin
          state_nxt = twe_pkg::TWE_IDLE;
          prog_cnt_nxt = 32'h0;
          page_nxt = '0;
        end else begin
          prog_cnt_nxt = prog_cnt_r + 32'h1;
        end
      end
      default: begin
        if (start_ev) begin
          state_nxt   = twe_pkg::TWE_ADDR;
          bit_nxt     = 4'h0;
          ack_nxt     = 1'b0;
          wr_any_nxt  = 1'b0;
          page_nxt    = '0;
        end else if (stop_ev) begin
          ack_nxt = 1'b0;
          // STOP with nothing latched, or after a read, just returns to idle
          if (state_r == twe_pkg::TWE_WDATA && wr_any_r) begin
            state_nxt    = twe_pkg::TWE_PROG;
            prog_cnt_nxt = 32'h0;
          end else begin
            state_nxt = twe_pkg::TWE_IDLE;
          end
        end else if (state_r == twe_pkg::TWE_ADDR || state_r == twe_pkg::TWE_WDATA) begin
          if (scl_rise && bit_r <= 4'(twe_pkg::BIT_LAST)) begin
            shift_nxt = {shift_r[6:0], sda_q_r};
            bit_nxt   = bit_r + 4'h1;
          end else if (scl_fall && bit_r == 4'(twe_pkg::BIT_ACK)) begin
            // Acknowledge lands with the filter lag; master needs a long low phase
            if (state_r == twe_pkg::TWE_ADDR) begin
              ack_nxt = 1'b1;
              addr_nxt = shift_r[7:1];
              // Read sequencing is not part of this block
              state_nxt = shift_r[0] ? twe_pkg::TWE_WAIT : twe_pkg::TWE_WDATA;
            end else begin
              ack_nxt = ~wp_seen_r;
              if (!wp_seen_r) begin
                page_nxt[addr_r[1:0]].data  = shift_r;
                page_nxt[addr_r[1:0]].valid = 1'b1;
                addr_nxt   = {addr_r[6:2], addr_r[1:0] + 2'h1};
                wr_any_nxt = 1'b1;
              end
            end
            bit_nxt = bit_r + 4'h1;
          end else if (scl_fall && bit_r == 4'(twe_pkg::BIT_ACK) + 4'h1) begin
            ack_nxt = 1'b0;
            bit_nxt = 4'h0;
          end
        end else if (state_r == twe_pkg::TWE_WAIT) begin
          // Read data is not driven; only the address acknowledge is dropped
          if (scl_fall && bit_r == 4'(twe_pkg::BIT_ACK) + 4'h1) begin
            ack_nxt = 1'b0;
            bit_nxt = 4'h0;
          end
        end
        // Protect level is caught from START to the end of the address byte
        if (start_ev) wp_seen_nxt = wp_q_r;
        else if (state_r == twe_pkg::TWE_ADDR) wp_seen_nxt = wp_seen_r | wp_q_r;
        else wp_seen_nxt = wp_seen_r; // Frozen after address byte
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_r      <= twe_pkg::TWE_IDLE;
      bit_r        <= 4'h0;
      shift_r      <= 8'h00;
      addr_r       <= 7'h00;
      wp_seen_r    <= 1'b0;
      ack_r        <= 1'b0;
      wr_any_r     <= 1'b0;
      prog_cnt_r   <= 32'h0;
      page_r       <= '0;
    end else begin
      state_r      <= state_nxt;
      bit_r        <= bit_nxt;
      shift_r      <= shift_nxt;
      addr_r       <= addr_nxt;
      wp_seen_r    <= wp_seen_nxt;
      ack_r        <= ack_nxt;
      wr_any_r     <= wr_any_nxt;
      prog_cnt_r   <= prog_cnt_nxt;
      page_r       <= page_nxt;
    end
  end

  // Array copy happens on the first program cycle; contents survive reset
  logic commit_now;
  assign commit_now = (state_r == twe_pkg::TWE_PROG) && (prog_cnt_r == 32'h0);
  always_ff @(posedge clock) begin
    if (commit_now) begin
      for (int i = 0; i < twe_pkg::PAGE_BYTES; i++) begin
        if (page_r[i].valid) mem_r[{addr_r[6:2], 2'(i)}] <= page_r[i].data;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) rd_data <= 8'h00;
    else rd_data <= mem_r[rd_addr];
  end

  // Open drain: the pin is only ever pulled low, never driven high
  assign sda_pin.sda_o  = 1'b0;
  assign sda_pin.sda_oe = ack_r;
  assign prog_busy      = (state_r == twe_pkg::TWE_PROG);
endmodule

// [sim/twe_slave_checker.sv]
// Port checker of the two-wire EEPROM write slave
`timescale 1ns/1ns
module twe_slave_checker #(
  parameter int PROG_CYCLES = twe_pkg::PROG_CYCLES
) (
  input wire logic              clock,
  input wire logic              reset_n,
  input wire logic              scl_i,
  input wire logic              sda_i,
  input wire logic              write_protect_input,
  input wire twe_pkg::twe_pin_t sda_pin,
  input wire logic              prog_busy,
  input wire logic [7:0]        rd_data,
  input wire logic [6:0]        rd_addr
);
  int unsigned busy_cnt_r;
  int unsigned stop_age_r = 100;
  logic        scl_d_r;
  logic        sda_d_r;
  always_ff @(posedge clock) begin
    scl_d_r    <= scl_i;
    sda_d_r    <= sda_i;
    busy_cnt_r <= (prog_busy && reset_n) ? busy_cnt_r + 1 : 0;
    if (scl_i && scl_d_r && sda_i && !sda_d_r) stop_age_r <= 0;
    else if (stop_age_r < 100) stop_age_r <= stop_age_r + 1;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence ack_pulse_s;
    sda_pin.sda_oe [*6] ##[1:6] !sda_pin.sda_oe;
  endsequence
  a_busy_stops: assert property (
    prog_busy && busy_cnt_r == PROG_CYCLES - 1 |=> !prog_busy) else $error("busy too long");
  a_busy_holds: assert property (
    prog_busy && busy_cnt_r < PROG_CYCLES - 1 |=> prog_busy) else $error("busy too short");
  a_busy_after_stop: assert property (
    $rose(prog_busy) |-> stop_age_r <= 8) else $error("busy without stop");
  a_ack_pulse: assert property (
    $rose(sda_pin.sda_oe) |-> ack_pulse_s) else $error("bad ack width");
  a_busy_released: assert property (
    prog_busy |-> !sda_pin.sda_oe) else $error("ack while busy");
  a_open_drain: assert property (
    sda_pin.sda_oe |-> sda_pin.sda_o == 1'b0) else $error("data driven high");
  a_idle_after: assert property (
    $fell(prog_busy) |-> !sda_pin.sda_oe [*8]) else $error("ack right after cycle");
  a_reset_quiet: assert property (disable iff (1'b0)
    !reset_n |=> !sda_pin.sda_oe && !prog_busy && rd_data == 8'h00) else $error("reset");
endmodule

// [sim/twe_mst.sv]
// Bus master model driving clock and data of the two-wire link
`timescale 1ns/1ns
module twe_mst (
  input wire logic clock,
  input wire logic sda_w,
  output logic     scl = 1'b1,
  output logic     sda = 1'b1,
  output logic     ack = 1'b0,
  output logic     ack_v = 1'b0
);
  // Long low phase so a lagging acknowledge still spans the high phase
  task automatic phase(input logic d, input int hi);
    scl <= 1'b0;
    repeat (3) @(posedge clock);
    sda <= d;
    repeat (2) @(posedge clock);
    scl <= 1'b1;
    repeat (hi) @(posedge clock);
  endtask
  task automatic bus_start();
    phase(1'b1, 4);
    sda <= 1'b0;
    repeat (4) @(posedge clock);
  endtask
  task automatic bus_stop();
    phase(1'b0, 4);
    sda <= 1'b1;
    repeat (4) @(posedge clock);
  endtask
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) phase(b[i], 3);
    phase(1'b1, 2);
    ack   <= ~sda_w;
    ack_v <= 1'b1;
    @(posedge clock);
    ack_v <= 1'b0;
  endtask
endmodule

// [sim/test_twe_slave.sv]
// Self-checking bench of the two-wire EEPROM write slave
`timescale 1ns/1ns
module test_twe_slave;
  localparam int     PC = 200;
  logic              clock = 1'b0;
  logic              reset_n = 1'b0;
  logic              wp = 1'b0;
  logic              rd_v = 1'b0;
  logic [6:0]        rd_addr = 7'h00;
  logic              scl, sda, ack, ack_v, prog_busy;
  logic [7:0]        rd_data, em [128], q [$];
  logic [31:0]       seed = 32'h1edf6417;
  twe_pkg::twe_pin_t pin;
  int                bad_count = 0, samples_checked = 0;
  wire               sda_w = sda & ~pin.sda_oe;
  always #5 clock = ~clock;
  twe_slave #(.PROG_CYCLES(PC)) twe_slave_inst (.clock(clock), .reset_n(reset_n),
    .scl_i(scl), .sda_i(sda_w), .write_protect_input(wp), .sda_pin(pin),
    .prog_busy(prog_busy), .rd_data(rd_data), .rd_addr(rd_addr));
  twe_mst twe_mst_inst (.clock(clock), .sda_w(sda_w), .scl(scl), .sda(sda), .ack(ack),
    .ack_v(ack_v));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checked %0d bad %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wb(input logic [7:0] b, input logic e);
    q.push_back({7'h00, e});
    twe_mst_inst.send(b);
  endtask
  task automatic rd(input logic [6:0] a);
    q.push_back(em[a]);
    rd_addr <= a;
    @(posedge clock);
    rd_v <= 1'b1;
    @(posedge clock);
    rd_v <= 1'b0;
  endtask
  always @(posedge clock) begin
    if (ack_v) chk({7'h00, ack}, q.pop_front());
    if (rd_v) chk(rd_data, q.pop_front());
  end
  initial begin
    logic [1:0] lo;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    repeat (4) @(posedge clock);
    twe_mst_inst.bus_start();
    wb(8'h2a, 1'b1);
    lo = 2'h1;
    // Fifth byte wraps back onto the first byte written in the row
    repeat (5) begin
      seed = lfsr(seed);
      em[{5'h05, lo}] = seed[7:0];
      wb(seed[7:0], 1'b1);
      lo++;
    end
    twe_mst_inst.bus_stop();
    twe_mst_inst.bus_start();
    wb(8'h2a, 1'b0);
    twe_mst_inst.bus_stop();
    for (int i = 0; i < 2 * PC && prog_busy !== 1'b0; i++) @(posedge clock);
    twe_mst_inst.bus_start();
    wb(8'h2a, 1'b1);
    twe_mst_inst.bus_stop();
    for (int a = 20; a < 24; a++) rd(7'(a));
    wp <= 1'b1;
    twe_mst_inst.bus_start();
    wb(8'h2a, 1'b1);
    wp <= 1'b0;
    seed = lfsr(seed);
    wb(seed[7:0], 1'b0);
    twe_mst_inst.bus_stop();
    rd(7'h15);
    twe_mst_inst.bus_start();
    wb(8'h55, 1'b1);
    twe_mst_inst.bus_stop();
    final_report();
  end
  initial begin
    repeat (5000) @(posedge clock);
    bad_count++;
    $display("BAD %0t run timed out", $time);
    final_report();
  end
endmodule
bind twe_slave twe_slave_checker #(.PROG_CYCLES(PROG_CYCLES)) twe_slave_checker_inst (
  .clock(clock), .reset_n(reset_n), .scl_i(scl_i), .sda_i(sda_i),
  .write_protect_input(write_protect_input), .sda_pin(sda_pin), .prog_busy(prog_busy),
  .rd_data(rd_data), .rd_addr(rd_addr));
